// ==== hw/stt_pkg.sv ====
/*
  Shared constants, types and register map of the scan trigger and
  totalizer block.
  Assumes a single 125 MHz core clock; all times are derived from it.
*/
`default_nettype none
package stt_pkg;
  // clock and time bases
  localparam int unsigned CLK_HZ    = 125_000_000;
  localparam int unsigned MS_PER_S  = 1000;
  localparam int unsigned US_PER_S  = 1_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S;
  // drift correction adds this much to each scan
  localparam int unsigned DRIFT_US      = 1500;
  localparam int unsigned DRIFT_CYC_DEF = DRIFT_US * CYC_PER_US;
  // debounce: shortest accepted input period
  localparam int unsigned DEB_US      = 2000;
  localparam int unsigned DEB_CYC_DEF = DEB_US * CYC_PER_US;
  // host silence before auto-disable
  localparam int unsigned SILENCE_S      = 30;
  localparam int unsigned SILENCE_MS_DEF = SILENCE_S * MS_PER_S;
  // scan length without drift correction, and scan queue depth
  localparam int unsigned SCAN_CYC = 64;
  localparam int unsigned QDEPTH   = 16;
  // interval limits and defaults in milliseconds, slot map reset value
  localparam logic [31:0] INT3_MAX_MS  = 32'(1000 * MS_PER_S);
  localparam logic [31:0] INT3_PREC_DEF = 32'(1 * MS_PER_S);
  localparam logic [31:0] INT3_PREC_MIN = 32'(500);
  localparam logic [31:0] INT3_FAST_DEF = 32'(100);
  localparam logic [31:0] INT3_FAST_MIN = 32'(50);
  localparam logic [31:0] INT1_RST      = 32'(MS_PER_S);
  localparam logic [31:0] INT2_RST      = 32'(100);
  localparam logic [11:0] SLOT_RST      = 12'h000;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_INT1   = 8'h04;
  localparam logic [7:0] OFS_INT2   = 8'h08;
  localparam logic [7:0] OFS_INT3   = 8'h0C;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  localparam logic [7:0] OFS_ISTAT  = 8'h14;
  localparam logic [7:0] OFS_IMASK  = 8'h18;
  localparam logic [7:0] OFS_TSTART = 8'h1C;
  localparam logic [7:0] OFS_TCOUNT = 8'h20;
  localparam logic [7:0] OFS_QPOP   = 8'h24;
  localparam logic [7:0] OFS_SLOT   = 8'h28;
  // interrupt status bit positions and width, number of slots
  localparam int IRQ_SCAN  = 0;
  localparam int IRQ_OVF   = 1;
  localparam int IRQ_ASTOP = 2;
  localparam int IRQ_CARD  = 3;
  localparam int IRQ_CFG   = 4;
  localparam int IRQ_W     = 5;
  localparam int NSLOT     = 6;

  typedef enum logic [1:0] {
    STT_TRIG_INTERVAL, STT_TRIG_EXT, STT_TRIG_ALARM, STT_TRIG_RSVD
  } stt_trig_t;
  typedef enum logic [1:0] {
    STT_STORE_ALWAYS, STT_STORE_ALARM, STT_STORE_TRANS, STT_STORE_RSVD
  } stt_store_t;
  typedef enum logic [1:0] {
    STT_RATE_SLOW, STT_RATE_MED, STT_RATE_FAST, STT_RATE_RSVD
  } stt_rate_t;
  typedef enum logic [1:0] {
    STT_SLOT_EMPTY, STT_SLOT_PREC, STT_SLOT_FAST, STT_SLOT_DIO
  } stt_slot_t;

  // control register, bit 0 upward: run .. trig_out_sel
  typedef struct packed {
    logic [17:0] rsvd;
    logic        trig_out_sel;
    logic        card_en;
    logic        ovf_overwrite;
    logic        autodis;
    logic        tot_down;
    logic        tot_deb;
    logic        drift_off;
    stt_rate_t   rate;
    stt_store_t  store;
    stt_trig_t   trig;
    logic        run;
  } stt_ctrl_t;
  localparam stt_ctrl_t CTRL_RST = '0;
endpackage : stt_pkg
`default_nettype wire

// ==== hw/stt_top.sv ====
/*
  Scan trigger sequencer and totalizer host of one instrument: interval,
  external and alarm triggering, alarm polling, scan queue policy,
  auto-disable, card logging, trigger output, slot checks, APB registers.
  Assumes APB master on core_clk; pins synchronous except trig_in_n.
*/
// Operation
// R01 - interval mode scans at interval 1
// R02 - one scan per external trigger activation
// R03 - held trigger repeats scans at interval 2
// R04 - alarm mode scans at interval 2 during alarm
// R05 - interval 3 polls alarms, max 1000 s
// R06 - precision module interval 3: 1 s, min 0.5 s
// R07 - fast module interval 3: 0.1 s, min 0.05 s
// R08 - auto-disable on full queue and silent host
// R09 - full queue overwrites or refuses per setting
// R10 - power-up option starts scanning without host
// R11 - full card stops card writes, scanning continues
// R12 - selected module drives trigger output to slaves
// R13 - drift correction forced unless fast rate
// R14 - storage: always, during alarm, or transitions
// R15 - debounce ignores periods below 2 ms
// R16 - totalizer counts up/down, reloads start count
// R17 - six slots, digital module only in slot 6
// R18 - synchronised trigger; no overlapping scans
`default_nettype none
module stt_top import stt_pkg::*; #(
  parameter int unsigned MS_CYC     = CYC_PER_MS,
  parameter int unsigned DRIFT_CYC  = DRIFT_CYC_DEF,
  parameter int unsigned DEB_CYC    = DEB_CYC_DEF,
  parameter int unsigned SILENCE_MS = SILENCE_MS_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trig_in_n,
  input  wire logic        alarm_trig,
  input  wire logic        alarm_any,
  input  wire logic        card_full_in,
  input  wire logic        tot_in,
  input  wire logic        start_strap,
  output logic             trig_out_n,
  output logic             scan_start,
  output logic             scan_store,
  output logic             card_wr,
  output logic             irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_STORE} stt_st_t;

  stt_ctrl_t          ctrl_q;
  stt_st_t            st_q;
  logic [31:0]        int1_q, int2_q, int3_q, tstart_q, scan_cnt_q;
  logic [31:0]        per [3];
  logic [11:0]        slot_q;
  logic [IRQ_W-1:0]   istat_q, imask_q, ev;
  logic [4:0]         qcnt_q;
  logic [NSLOT-2:0]   bad_slot;
  logic [2:0]         tmr_en, tmr_tick;
  logic [$clog2(MS_CYC)-1:0] ms_cnt_q;
  logic [31:0]        silent_q, tot_count;
  logic ms_tick, boot_q, alm_act_q, alm_prev_q, card_full_q;
  logic trig_s1_q, trig_s2_q, trig_s3_q, ext_fall, held;
  logic acc, wr, rd, req, store_ok, q_full, pop, push, astop;
  logic cfg_err, fast_mod, drift_on;

  // interval 3 bounds depend on the module type
  function automatic logic [31:0] clamp3(input logic [31:0] v,
                                         input logic fast);
    logic [31:0] lo;
    lo = fast ? INT3_FAST_MIN : INT3_PREC_MIN;
    if (v > INT3_MAX_MS) clamp3 = INT3_MAX_MS;
    else if (v < lo) clamp3 = lo;
    else clamp3 = v;
  endfunction : clamp3

  assign acc = psel & penable & pready;
  assign wr  = acc & pwrite;
  assign rd  = acc & ~pwrite;

  // slots 1..5 must not hold the digital module [R17]
  generate
    for (genvar s = 0; s < NSLOT - 1; s++) begin : g_slot
      assign bad_slot[s] = slot_q[2*s +: 2] == STT_SLOT_DIO;
    end
  endgenerate
  assign cfg_err  = |bad_slot; // [R17]
  assign fast_mod = slot_q[1:0] == STT_SLOT_FAST;
  // drift correction may be dropped only at the fast rate [R13]
  assign drift_on = ~ctrl_q.drift_off | (ctrl_q.rate != STT_RATE_FAST);

  // apb setup: zero wait state, answer in the access cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel & ~penable) begin
        if (paddr == OFS_CTRL) prdata <= ctrl_q;
        else if (paddr == OFS_INT1) prdata <= int1_q;
        else if (paddr == OFS_INT2) prdata <= int2_q;
        else if (paddr == OFS_INT3) prdata <= int3_q;
        else if (paddr == OFS_STAT)
          prdata <= {22'h00_0000, qcnt_q, card_full_q, alm_act_q,
                     st_q != ST_IDLE, cfg_err, ctrl_q.run};
        else if (paddr == OFS_ISTAT) prdata <= 32'(istat_q);
        else if (paddr == OFS_IMASK) prdata <= 32'(imask_q);
        else if (paddr == OFS_TSTART) prdata <= tstart_q;
        else if (paddr == OFS_TCOUNT) prdata <= tot_count;
        else if (paddr == OFS_QPOP) prdata <= 32'(qcnt_q);
        else if (paddr == OFS_SLOT) prdata <= 32'(slot_q);
        else pslverr <= 1'b1; // unmapped: error, reads zero
      end
    end
  end

  // control word; power-up start caught once after reset release
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= CTRL_RST;
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
      if (boot_q && start_strap) ctrl_q.run <= 1'b1; // [R10]
      if (wr && paddr == OFS_CTRL) begin
        ctrl_q      <= stt_ctrl_t'(pwdata);
        ctrl_q.rsvd <= '0;
      end else if (astop) begin
        ctrl_q.run <= 1'b0; // [R08]
      end
    end
  end

  // interval periods and slot map
  always_ff @(posedge core_clk) begin
    if (srst) begin
      int1_q   <= INT1_RST;
      int2_q   <= INT2_RST;
      int3_q   <= INT3_PREC_DEF; // [R06]
      tstart_q <= '0;
      slot_q   <= SLOT_RST;
      imask_q  <= '0;
    end else if (wr) begin
      if (paddr == OFS_INT1) int1_q <= pwdata; // [R01]
      else if (paddr == OFS_INT2) int2_q <= pwdata;
      else if (paddr == OFS_INT3)
        int3_q <= clamp3(pwdata, fast_mod); // [R05] [R06] [R07]
      else if (paddr == OFS_TSTART) tstart_q <= pwdata;
      else if (paddr == OFS_IMASK) imask_q <= pwdata[IRQ_W-1:0];
      else if (paddr == OFS_SLOT) begin
        slot_q <= pwdata[11:0];
        // new module type brings its own interval 3 default
        int3_q <= (pwdata[1:0] == STT_SLOT_FAST) ? INT3_FAST_DEF // [R07]
                                                  : INT3_PREC_DEF;
      end
    end
  end

  // millisecond enable for all interval timers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ms_cnt_q <= '0;
      ms_tick  <= 1'b0;
    end else begin
      ms_tick  <= ms_cnt_q == $bits(ms_cnt_q)'(MS_CYC - 1);
      ms_cnt_q <= (ms_cnt_q == $bits(ms_cnt_q)'(MS_CYC - 1))
                  ? '0 : ms_cnt_q + 1'b1;
    end
  end

  // trigger pin: two-stage synchroniser, then falling edge [R18]
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trig_s1_q <= 1'b1;
      trig_s2_q <= 1'b1;
      trig_s3_q <= 1'b1;
    end else begin
      trig_s1_q <= trig_in_n;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end
  assign ext_fall = ~trig_s2_q & trig_s3_q; // [R02]
  assign held     = ~trig_s2_q;

  // timer enables: 1 periodic, 2 held trigger or alarm, 3 alarm poll
  assign tmr_en[0] = ctrl_q.run & (ctrl_q.trig != STT_TRIG_EXT);
  assign tmr_en[1] = ctrl_q.run &
      (((ctrl_q.trig == STT_TRIG_EXT) & held) | // [R03]
       ((ctrl_q.trig == STT_TRIG_ALARM) & alm_act_q)); // [R04]
  assign tmr_en[2] = ctrl_q.run & (ctrl_q.trig == STT_TRIG_ALARM); // [R05]
  assign per[0] = int1_q;
  assign per[1] = int2_q;
  assign per[2] = int3_q;

  // three interval timers; a disabled timer restarts from zero
  generate
    for (genvar g = 0; g < 3; g++) begin : g_tmr
      logic [31:0] cnt_q;
      logic        tick_q;
      // one flop per timer keeps each tick bit single-driven
      assign tmr_tick[g] = tick_q;
      always_ff @(posedge core_clk) begin
        if (srst || !tmr_en[g]) begin
          cnt_q  <= '0;
          tick_q <= 1'b0;
        end else begin
          tick_q <= 1'b0;
          if (ms_tick) begin
            if (cnt_q + 32'd1 >= per[g]) begin
              cnt_q  <= '0;
              tick_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 32'd1;
            end
          end
        end
      end
    end
  endgenerate

  // alarm state is sampled on each interval 3 poll [R05]
  always_ff @(posedge core_clk) begin
    if (srst || !tmr_en[2]) alm_act_q <= 1'b0;
    else if (tmr_tick[2]) alm_act_q <= alarm_trig; // [R04]
  end

  // scan requests per trigger mode
  always_comb begin
    case (ctrl_q.trig)
      STT_TRIG_INTERVAL: req = tmr_tick[0]; // [R01]
      STT_TRIG_EXT:      req = ext_fall | tmr_tick[1]; // [R02] [R03]
      STT_TRIG_ALARM:    req = tmr_tick[0] | tmr_tick[1]; // [R04]
      default:           req = 1'b0;
    endcase
  end

  // scan sequencer; requests while busy are dropped [R18]
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q       <= ST_IDLE;
      scan_cnt_q <= '0;
      scan_start <= 1'b0;
      trig_out_n <= 1'b1;
    end else begin
      scan_start <= 1'b0;
      trig_out_n <= 1'b1;
      case (st_q)
        ST_IDLE: begin
          if (req && ctrl_q.run && !cfg_err) begin // [R17] [R18]
            st_q       <= ST_SCAN;
            scan_start <= 1'b1;
            trig_out_n <= ~ctrl_q.trig_out_sel; // [R12]
            scan_cnt_q <= drift_on ? 32'(SCAN_CYC + DRIFT_CYC) // [R13]
                                   : 32'(SCAN_CYC);
          end
        end
        ST_SCAN: begin
          scan_cnt_q <= scan_cnt_q - 32'd1;
          if (scan_cnt_q <= 32'd1) st_q <= ST_STORE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // storage policy at the end of each scan [R14]
  always_comb begin
    case (ctrl_q.store)
      STT_STORE_ALWAYS: store_ok = 1'b1;
      STT_STORE_ALARM:  store_ok = alarm_any;
      STT_STORE_TRANS:  store_ok = alarm_any ^ alm_prev_q;
      default:          store_ok = 1'b1;
    endcase
  end
  assign q_full = qcnt_q == 5'(QDEPTH);
  assign push   = (st_q == ST_STORE) & store_ok;
  assign pop    = rd & (paddr == OFS_QPOP) & (qcnt_q != '0);

  // scan queue occupancy; full queue overwrites oldest or refuses [R09]
  always_ff @(posedge core_clk) begin
    if (srst) begin
      qcnt_q     <= '0;
      alm_prev_q <= 1'b0;
      scan_store <= 1'b0;
    end else begin
      scan_store <= push & (~q_full | ctrl_q.ovf_overwrite | pop);
      if (st_q == ST_STORE) alm_prev_q <= alarm_any;
      if (push && !pop && !q_full) qcnt_q <= qcnt_q + 5'd1;
      else if (pop && !push) qcnt_q <= qcnt_q - 5'd1;
    end
  end

  // card logging stops at card full; scans keep going [R11]
  always_ff @(posedge core_clk) begin
    if (srst) begin
      card_full_q <= 1'b0;
      card_wr     <= 1'b0;
    end else begin
      card_wr <= push & ctrl_q.card_en & ~card_full_q & ~card_full_in;
      if (card_full_in) card_full_q <= 1'b1;
      else if (!ctrl_q.card_en) card_full_q <= 1'b0;
    end
  end

  // host silence in milliseconds, any bus access restarts it [R08]
  always_ff @(posedge core_clk) begin
    if (srst || acc) silent_q <= '0;
    else if (ms_tick && silent_q <= 32'(SILENCE_MS))
      silent_q <= silent_q + 32'd1;
  end
  assign astop = ctrl_q.run & ctrl_q.autodis & q_full &
                 (silent_q > 32'(SILENCE_MS)); // [R08]

  // sticky events; a new event wins over a write-one clear
  always_comb begin
    ev            = '0;
    ev[IRQ_SCAN]  = st_q == ST_STORE;
    ev[IRQ_OVF]   = push & q_full & ~pop; // [R09]
    ev[IRQ_ASTOP] = astop;
    ev[IRQ_CARD]  = card_full_in & ~card_full_q;
    ev[IRQ_CFG]   = req & cfg_err & ctrl_q.run;
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      istat_q <= '0;
      irq     <= 1'b0;
    end else begin
      if (wr && paddr == OFS_ISTAT)
        istat_q <= (istat_q & ~pwdata[IRQ_W-1:0]) | ev;
      else istat_q <= istat_q | ev;
      irq <= |(istat_q & imask_q);
    end
  end

  // digital module counter lives in slot 6 only [R17]
  stt_totalizer #(.DEB_CYC(DEB_CYC)) u_tot (
    .core_clk (core_clk),
    .srst     (srst),
    .en       (slot_q[11:10] == STT_SLOT_DIO),
    .deb      (ctrl_q.tot_deb), // [R15]
    .down     (ctrl_q.tot_down), // [R16]
    .load     (wr && paddr == OFS_TCOUNT),
    .start    (tstart_q),
    .cnt_in   (tot_in),
    .count    (tot_count)
  );

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_int1;
    st_q == ST_IDLE && ctrl_q.run && !cfg_err &&
    ctrl_q.trig == STT_TRIG_INTERVAL && tmr_tick[0] |=> scan_start;
  endproperty
  a_int1: assert property (p_int1) // [R01]
    else $error("interval tick did not start a scan");

  property p_ext;
    st_q == ST_IDLE && ctrl_q.run && !cfg_err &&
    ctrl_q.trig == STT_TRIG_EXT && ext_fall |=> scan_start ##1 !scan_start;
  endproperty
  a_ext: assert property (p_ext) // [R02]
    else $error("trigger edge did not give one scan");

  property p_held;
    ctrl_q.trig == STT_TRIG_EXT && ctrl_q.run && !held |=> !tmr_tick[1];
  endproperty
  a_held: assert property (p_held) // [R03]
    else $error("interval 2 ran without held trigger");

  property p_alarm;
    ctrl_q.trig == STT_TRIG_ALARM && !alm_act_q |=> !tmr_tick[1];
  endproperty
  a_alarm: assert property (p_alarm) // [R04]
    else $error("interval 2 ran without alarm");

  property p_int3;
    int3_q <= INT3_MAX_MS &&
    int3_q >= (fast_mod ? INT3_FAST_MIN : INT3_PREC_MIN);
  endproperty
  a_int3: assert property (p_int3) // [R05]
    else $error("interval 3 out of bounds");

  property p_astop;
    astop && !wr |=> !ctrl_q.run;
  endproperty
  a_astop: assert property (p_astop) // [R08]
    else $error("auto-disable did not stop scanning");

  property p_refuse;
    push && q_full && !pop && !ctrl_q.ovf_overwrite |=> !scan_store;
  endproperty
  a_refuse: assert property (p_refuse) // [R09]
    else $error("full queue accepted a scan");

  property p_card;
    card_full_q |=> !card_wr;
  endproperty
  a_card: assert property (p_card) // [R11]
    else $error("card written while full");

  property p_drift;
    scan_start && ctrl_q.rate != STT_RATE_FAST |->
      scan_cnt_q == 32'(SCAN_CYC + DRIFT_CYC);
  endproperty
  a_drift: assert property (p_drift) // [R13]
    else $error("drift correction skipped at slow rate");

  property p_overlap;
    scan_start |-> $past(st_q) == ST_IDLE && !$past(cfg_err);
  endproperty
  a_overlap: assert property (p_overlap) // [R17] [R18]
    else $error("scan started while busy or misconfigured");

  c_ext: cover property (ctrl_q.trig == STT_TRIG_EXT && scan_start);
  c_alarm: cover property (alm_act_q && tmr_tick[1] ##1 scan_start);
  c_astop: cover property (astop);
endmodule : stt_top
`default_nettype wire

// ==== hw/stt_totalizer.sv ====
/*
  Totalizer of the digital I/O module: edge counter with start-count
  reload, up/down direction and optional debounce.
  Assumes the counted input is already synchronous to core_clk.
*/
`default_nettype none
module stt_totalizer import stt_pkg::*; #(
  parameter int unsigned DEB_CYC = DEB_CYC_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        en,
  input  wire logic        deb,
  input  wire logic        down,
  input  wire logic        load,
  input  wire logic [31:0] start,
  input  wire logic        cnt_in,
  output logic      [31:0] count
);
  logic        prev_q;
  logic [31:0] gap_q;
  logic        rise;
  logic        take;

  assign rise = cnt_in & ~prev_q;
  // short periods are dropped only when debouncing [R15]
  assign take = en & rise & (~deb | (gap_q >= 32'(DEB_CYC)));

  // edge history and period measurement, saturating
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prev_q <= 1'b0;
      gap_q  <= '0;
    end else begin
      prev_q <= cnt_in;
      if (rise) gap_q <= '0;
      else if (gap_q != '1) gap_q <= gap_q + 32'd1;
    end
  end

  // count toward zero or up; reload the start count at terminal [R16]
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count <= '0;
    end else if (load) begin
      count <= start;
    end else if (take) begin
      if (down) count <= (count == '0) ? start : count - 32'd1;
      else if (count == '1) count <= start;
      else count <= count + 32'd1;
    end
  end

  property p_deb_drop;
    @(posedge core_clk) disable iff (srst)
    en && deb && rise && gap_q < 32'(DEB_CYC) && !load |=> $stable(count);
  endproperty
  a_deb_drop: assert property (p_deb_drop) // [R15]
    else $error("debounced pulse was counted");

  property p_down_reload;
    @(posedge core_clk) disable iff (srst)
    take && down && count == '0 && !load |=> count == $past(start);
  endproperty
  a_down_reload: assert property (p_down_reload) // [R16]
    else $error("start count not reloaded at zero");
endmodule : stt_totalizer
`default_nettype wire

// ==== tb/stt_top_tb.sv ====
/*
  Self-checking bench of the scan trigger block: registers over APB,
  interval and external triggering, interrupt.
  Assumes short time parameters: 10 cycles per ms, drift 20 cycles.
*/
`default_nettype none
module stt_top_tb import stt_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk = 1'b0;
  logic       srst     = 1'b1;
  logic       psel     = 1'b0;
  logic       penable  = 1'b0;
  logic       pwrite   = 1'b0;
  logic [7:0] paddr    = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic       pready, pslverr, se, trig_in_n, trig_out_n;
  logic       scan_start, scan_store, card_wr, irq;
  logic       go       = 1'b0;
  logic       alarm_trig = 1'b0;
  logic       alarm_any  = 1'b0;
  logic       card_full  = 1'b0;
  logic       tot_in     = 1'b0;
  logic       strap      = 1'b0;
  logic [8:0] len      = 9'h000;
  int         err_total = 0;
  int         checked   = 0;
  int         n, k;

  always #4 core_clk = ~core_clk;

  stt_top #(.MS_CYC(10), .DRIFT_CYC(20), .DEB_CYC(8), .SILENCE_MS(3)) dut (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_in_n(trig_in_n),
    .alarm_trig(alarm_trig), .alarm_any(alarm_any), .card_full_in(card_full),
    .tot_in(tot_in), .start_strap(strap), .trig_out_n(trig_out_n),
    .scan_start(scan_start), .scan_store(scan_store), .card_wr(card_wr),
    .irq(irq));
  stt_trig_src src (.core_clk(core_clk), .go(go), .len(len),
    .trig_n(trig_in_n));

  task automatic close_out;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic fail(input string m);
    err_total++;
    $display("[ERR] %0t %s", $time, m);
    close_out();
  endtask : fail

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp

  // one APB transfer; request held until pready is seen high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int c;
    c = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      c++;
    end while (pready !== 1'b1 && c < 20);
    if (c >= 20) fail("apb hang");
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    cmp(rd, exp, "read value");
  endtask : rdc

  // cycles until the next scan start
  task automatic wstart(input int lim, output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (scan_start !== 1'b1 && c < lim);
    if (c >= lim) fail("no scan start");
  endtask : wstart

  task automatic nstart(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      if (scan_start === 1'b1) c++;
    end
  endtask : nstart

  task automatic pulse(input logic [8:0] l);
    @(posedge core_clk);
    len <= l;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
  endtask : pulse

  // pulses of scan_store and card_wr within a window
  task automatic nstore(input int cyc, output int s, output int w);
    s = 0;
    w = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      if (scan_store === 1'b1) s++;
      if (card_wr === 1'b1) w++;
    end
  endtask : nstore

  // three counter input pulses, two cycles apart
  task automatic totp;
    repeat (3) begin
      @(posedge core_clk);
      tot_in <= 1'b1;
      @(posedge core_clk);
      tot_in <= 1'b0;
    end
  endtask : totp

  // reset values, unmapped address, interval 3 limits per slot 1 type
  task automatic t_regs;
    rdc(OFS_CTRL, 32'h0000_0000);
    rdc(OFS_INT3, 32'h0000_03E8);
    bus(1'b0, 8'hFC, 32'h0000_0000);
    cmp(32'(se), 32'h0000_0001, "unmapped slverr");
    bus(1'b1, OFS_INT3, 32'h0000_000A);
    rdc(OFS_INT3, 32'h0000_01F4);
    bus(1'b1, OFS_INT3, 32'h00FF_FFFF);
    rdc(OFS_INT3, 32'h000F_4240);
    bus(1'b1, OFS_SLOT, 32'h0000_0002);
    rdc(OFS_INT3, 32'h0000_0064);
    bus(1'b1, OFS_INT3, 32'h0000_000A);
    rdc(OFS_INT3, 32'h0000_0032);
    bus(1'b1, OFS_SLOT, 32'h0000_0000);
  endtask : t_regs

  // 20 ms interval gives 200 cycles between starts, then irq flow
  task automatic t_int;
    bus(1'b1, OFS_INT1, 32'h0000_0014);
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    wstart(400, n);
    wstart(400, n);
    cmp(32'(n), 32'h0000_00C8, "interval gap");
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
    repeat (100) @(posedge core_clk);
    rdc(OFS_ISTAT, 32'h0000_0001);
    cmp(32'(irq), 32'h0000_0000, "irq masked");
    bus(1'b1, OFS_IMASK, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    cmp(32'(irq), 32'h0000_0001, "irq raised");
    bus(1'b1, OFS_ISTAT, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    cmp(32'(irq), 32'h0000_0000, "irq cleared");
  endtask : t_int

  // single activation, retrigger while busy, then a held trigger
  task automatic t_ext;
    bus(1'b1, OFS_INT2, 32'h0000_000A);
    bus(1'b1, OFS_CTRL, 32'h0000_2003);
    pulse(9'h003);
    wstart(20, n);
    cmp(32'(trig_out_n), 32'h0000_0000, "trigger out");
    pulse(9'h003);
    nstart(300, k);
    cmp(32'(k), 32'h0000_0000, "extra scans");
    pulse(9'h0FF);
    nstart(280, k);
    cmp(32'(k), 32'h0000_0003, "held scans");
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
  endtask : t_ext

  // card logging until full, then alarm-only storage
  task automatic t_card;
    bus(1'b1, OFS_CTRL, 32'h0000_1003);
    pulse(9'h003);
    nstore(120, n, k);
    cmp(32'(n), 32'h0000_0001, "stored");
    cmp(32'(k), 32'h0000_0001, "card write");
    card_full <= 1'b1;
    pulse(9'h003);
    card_full <= 1'b0;
    nstore(120, n, k);
    cmp(32'(n), 32'h0000_0001, "stored, card full");
    cmp(32'(k), 32'h0000_0000, "card write when full");
    bus(1'b1, OFS_CTRL, 32'h0000_000B);
    pulse(9'h003);
    nstore(120, n, k);
    cmp(32'(n), 32'h0000_0000, "stored without alarm");
    alarm_any <= 1'b1;
    pulse(9'h003);
    nstore(120, n, k);
    cmp(32'(n), 32'h0000_0001, "stored in alarm");
    alarm_any <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
  endtask : t_card

  // slot 6 counter: start-count load, up count, debounced down count
  task automatic t_tot;
    bus(1'b1, OFS_SLOT, 32'h0000_0C00);
    bus(1'b1, OFS_TSTART, 32'h0000_0005);
    bus(1'b1, OFS_TCOUNT, 32'h0000_0000);
    totp();
    rdc(OFS_TCOUNT, 32'h0000_0008);
    bus(1'b1, OFS_CTRL, 32'h0000_0300);
    repeat (10) @(posedge core_clk);
    totp();
    rdc(OFS_TCOUNT, 32'h0000_0007);
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
    bus(1'b1, OFS_SLOT, 32'h0000_0000);
  endtask : t_tot

  // reset in mid-run with the power-up option strapped
  task automatic t_boot;
    @(posedge core_clk);
    srst <= 1'b1;
    strap <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rdc(OFS_CTRL, 32'h0000_0001);
    strap <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
  endtask : t_boot

  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    t_regs();
    t_int();
    t_ext();
    t_card();
    t_tot();
    t_boot();
    close_out();
  end
endmodule : stt_top_tb
`default_nettype wire

// ==== tb/stt_trig_src.sv ====
/*
  Partner model: another instrument's trigger output feeding our input.
  Assumes the line is pulled high when nobody drives it low.
*/
`default_nettype none
module stt_trig_src (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [8:0] len,
  output logic            trig_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] left_q = 9'h000;
  // low for len cycles per request, a held level when len is large
  always_ff @(posedge core_clk) begin
    if (go) begin
      left_q <= len;
    end else if (left_q != 9'h000) begin
      left_q <= left_q - 9'h001;
    end
  end
  // released line goes to its pull-up level
  assign trig_n = (left_q == 9'h000);
endmodule : stt_trig_src
`default_nettype wire
